//--- emu_bus_pkg.sv
/*
 * Shared types and constants of the emulation bus interface: access kinds,
 * the core request carrier, cycle counts and control register layout.
 * Assumes a single core-side clock (mclk) and a link clock for the pins.
 */
package emu_bus_pkg;

	// Clock figures in picoseconds
	localparam int MCLK_PERIOD_PS = 8000;
	localparam int LINK_PERIOD_PS = 6000;

	// Register strobe width: must outlast the three-stage input filter
	localparam int STROBE_TIME_PS = 36000;
	localparam logic [3:0] STROBE_CYCLES = 4'((STROBE_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
	// Extra strobe cycles added when extended timing is selected
	localparam int EXTEND_TIME_PS = 12000;
	localparam logic [3:0] EXTEND_CYCLES = 4'((EXTEND_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);

	// Emulation control register
	localparam logic [7:0] EMU_CTRL_RESET = 8'h00;
	localparam int EMU_CTRL_EXT_BIT = 0;

	// Bank that holds the on-board register file
	localparam logic [3:0] ONBOARD_BANK = 4'h0;

	// Memory size select codes
	localparam logic [2:0] SIZE_NONE = 3'h0;
	localparam logic [2:0] SIZE_2K = 3'h1;
	localparam logic [2:0] SIZE_4K = 3'h2;
	localparam logic [2:0] SIZE_8K = 3'h3;
	localparam logic [2:0] SIZE_16K = 3'h4;
	localparam logic [2:0] SIZE_32K = 3'h5;

	// Reset value of the data and address buses
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] ADDR_RESET = 16'h0000;

	typedef enum logic [2:0] {
		ACC_REG_READ,
		ACC_REG_WRITE,
		ACC_FETCH,
		ACC_DATA_READ,
		ACC_DATA_WRITE
	} access_kind_t;

	typedef struct packed {
		access_kind_t kind;
		logic [3:0] bank;
		logic [7:0] regAddr;
		logic [7:0] wdata;
		logic [15:0] memAddr;
	} core_req_t;

	// Request as it crosses to the link side, with the timing choice attached
	typedef struct packed {
		core_req_t req;
		logic extended;
	} link_req_t;

	// Core status levels and events that leave the chip on pins
	typedef struct packed {
		logic instrEnd;
		logic intCycle;
		logic haltMode;
		logic stopMode;
	} core_status_t;

	// Pin levels the core sees
	typedef struct packed {
		logic timersRun;
		logic clockHeld;
		logic waitReq;
		logic wakeReq;
	} core_ctrl_t;

endpackage : emu_bus_pkg

//--- emu_core_bus_interface.sv
/*
 * Emulation core bus interface: takes register and memory accesses from the
 * core on mclk, runs them on the external pins on the link clock, and carries
 * status and control pins between the core and the emulator logic outside.
 * Assumes the core holds its request until reqBusy falls and the rspValid
 * pulse arrives, and that outside logic keeps bus inputs steady while the
 * matching strobe is low.
 */
// Behaviour
// - Mux select low shares low address byte.
// - Drive four-bit register bank pointer.
// - Drive eight-bit register address within bank.
// - Write cycles drive data, write strobe low.
// - Read cycles strobe low, outside returns byte.
// - Expanded file select only for expanded banks.
// - Data space strobe low on data accesses.
// - Internal data strobe low on internal fetch.
// - Both address strobes low in first state.
// - External data strobe low on external fetch.
// - Sync pulse on last instruction clock.
// - Interrupt acknowledge low during interrupt cycle.
// - Freeze input low halts all timers.
// - Hold input low stops internal clock.
// - Wait stops after instruction, latches fetch address.
// - Halt indicator low while in halt.
// - Stop indicator low while in stop.
// - Wake input low brings core out of stop.
// - Timer clock and inverted system clock output.
// - Control register selects normal or extended timing.
module emu_core_bus_interface (
	input wire logic mclk,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic reqValid,
	input wire emu_bus_pkg::core_req_t req,
	output logic reqBusy,
	output logic rspValid,
	output logic [7:0] rspData,
	input wire logic emuCtrlWrite,
	input wire logic [7:0] emuCtrlData,
	output logic [7:0] emuControlReg,
	input wire emu_bus_pkg::core_status_t coreStatus,
	output emu_bus_pkg::core_ctrl_t coreCtrl,
	input wire logic addrDataMuxSelN,
	input wire logic [2:0] memSizeSel,
	output logic [15:0] memAddrBus,
	input wire logic [7:0] memDataBusIn,
	output logic [7:0] memDataBusOut,
	output logic memDataBusOe,
	output logic [3:0] regBankPtr,
	output logic [7:0] regAddrBus,
	output logic [7:0] regWriteBus,
	input wire logic [7:0] regReadBus,
	output logic regWriteStrobeN,
	output logic regReadStrobeN,
	output logic extRegfileSelectN,
	output logic dataSpaceStrobeN,
	output logic intMemDataStrobeN,
	output logic intMemAddrStrobeN,
	output logic extDataStrobeN,
	output logic extAddrStrobeN,
	output logic instrSync,
	output logic intAckN,
	input wire logic timersFreezeN,
	input wire logic clockHoldN,
	input wire logic waitN,
	output logic haltIndN,
	output logic stopIndN,
	input wire logic stopWakeN,
	output logic sysClk,
	output logic sysClkInv,
	output logic timerTickClk
);
	import emu_bus_pkg::*;

	// Upper bound of internal program memory for a size code
	function automatic logic [16:0] memLimit(input logic [2:0] sel);
		case (sel)
			SIZE_NONE: memLimit = 17'h00000;
			SIZE_2K: memLimit = 17'h00800;
			SIZE_4K: memLimit = 17'h01000;
			SIZE_8K: memLimit = 17'h02000;
			SIZE_16K: memLimit = 17'h04000;
			SIZE_32K: memLimit = 17'h08000;
			default: memLimit = 17'h08000; // Unlisted codes behave as largest
		endcase
	endfunction : memLimit

	// Filtered async input: takes the new value only once stages two and three agree
	function automatic logic filterBit(input logic b, input logic c, input logic q);
		filterBit = (b == c) ? c : q;
	endfunction : filterBit

	// ---------------- mclk domain ----------------
	localparam int MW = 5;
	logic [MW-1:0] mRaw;
	logic [MW-1:0] mS1;
	logic [MW-1:0] mS2;
	logic [MW-1:0] mS3;
	logic [MW-1:0] mQ;
	logic reqTgl;
	logic instrTgl;
	logic ackTgl;
	logic ackSeen;
	logic [7:0] linkRdata;
	link_req_t reqHold;

	assign mRaw = {ackTgl, timersFreezeN, clockHoldN, waitN, stopWakeN};

	// Three-stage filter of everything arriving from outside mclk
	always_ff @(posedge mclk) begin
		if (rst) begin
			mS1 <= '0;
			mS2 <= '0;
			mS3 <= '0;
			mQ <= 5'h0F; // Pulled-up pins idle high, ack toggle low
		end else begin
			mS1 <= mRaw;
			mS2 <= mS1;
			mS3 <= mS2;
			for (int i = 0; i < MW; i++) begin
				mQ[i] <= filterBit(mS2[i], mS3[i], mQ[i]);
			end
		end
	end

	// Emulation control register; bit chooses extended strobe timing for every access
	always_ff @(posedge mclk) begin
		if (rst) begin
			emuControlReg <= EMU_CTRL_RESET;
		end else if (emuCtrlWrite) begin
			emuControlReg <= emuCtrlData;
		end
	end

	// Request handshake: toggle out, toggle back; data held stable meanwhile
	always_ff @(posedge mclk) begin
		if (rst) begin
			reqTgl <= 1'b0;
			reqBusy <= 1'b0;
			reqHold <= '0;
			ackSeen <= 1'b0;
			rspValid <= 1'b0;
			rspData <= BYTE_RESET;
		end else begin
			rspValid <= 1'b0;
			if (!reqBusy && reqValid) begin
				reqHold.req <= req;
				reqHold.extended <= emuControlReg[EMU_CTRL_EXT_BIT];
				reqTgl <= ~reqTgl;
				reqBusy <= 1'b1;
			end else if (reqBusy && mQ[4] != ackSeen) begin
				ackSeen <= mQ[4];
				reqBusy <= 1'b0;
				rspValid <= 1'b1;
				rspData <= linkRdata; // Stable since the ack toggle left the link side
			end
		end
	end

	// Instruction-end events cross as a toggle
	always_ff @(posedge mclk) begin
		if (rst) begin
			instrTgl <= 1'b0;
		end else if (coreStatus.instrEnd) begin
			instrTgl <= ~instrTgl;
		end
	end

	// Pin levels presented to the core
	always_ff @(posedge mclk) begin
		if (rst) begin
			coreCtrl <= '0;
		end else begin
			coreCtrl.timersRun <= mQ[3];
			coreCtrl.clockHeld <= ~mQ[2];
			coreCtrl.waitReq <= ~mQ[1];
			coreCtrl.wakeReq <= ~mQ[0];
		end
	end

	// ---------------- link domain ----------------
	localparam int LW = 27;
	logic [LW-1:0] lRaw;
	logic [LW-1:0] lS1;
	logic [LW-1:0] lS2;
	logic [LW-1:0] lS3;
	logic [LW-1:0] lQ;
	logic [2:0] lRstPipe;
	logic lRst;
	logic reqSeen;
	logic instrSeen;
	logic instrDone;
	logic [3:0] cnt;
	logic [15:0] fetchAddr;
	link_req_t cur;
	logic isMem;
	logic isIntFetch;

	typedef enum {L_IDLE, L_T1, L_T2, L_T3, L_WAIT} link_state_t;
	link_state_t state;

	// Field positions inside the link filter vector
	wire lReqTgl = lQ[26];
	wire lInstrTgl = lQ[25];
	wire lIntCycle = lQ[24];
	wire lHalt = lQ[23];
	wire lStop = lQ[22];
	wire lHoldN = lQ[21];
	wire lWaitN = lQ[20];
	wire lMuxN = lQ[19];
	wire [2:0] lSize = lQ[18:16];
	wire [7:0] lRegRd = lQ[15:8];
	wire [7:0] lMemRd = lQ[7:0];

	assign lRaw = {reqTgl, instrTgl, coreStatus.intCycle, coreStatus.haltMode, coreStatus.stopMode,
		clockHoldN, waitN, addrDataMuxSelN, memSizeSel, regReadBus, memDataBusIn};

	// Reset carried into the link domain
	always_ff @(posedge linkClk) begin
		lRstPipe <= {lRstPipe[1:0], rst};
	end
	assign lRst = lRstPipe[2];

	// Three-stage filter of everything arriving from outside linkClk
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			lS1 <= '0;
			lS2 <= '0;
			lS3 <= '0;
			lQ <= 27'h0380000; // Pulled-up pins idle high
		end else begin
			lS1 <= lRaw;
			lS2 <= lS1;
			lS3 <= lS2;
			for (int i = 0; i < LW; i++) begin
				lQ[i] <= filterBit(lS2[i], lS3[i], lQ[i]);
			end
		end
	end

	assign isMem = cur.req.kind == ACC_FETCH || cur.req.kind == ACC_DATA_READ || cur.req.kind == ACC_DATA_WRITE;
	assign isIntFetch = cur.req.kind == ACC_FETCH && {1'b0, cur.req.memAddr} < memLimit(lSize);

	// Access sequencer: first state, strobe state, release, and wait parking
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			state <= L_IDLE;
			cnt <= 4'h0;
			cur <= '0;
			reqSeen <= 1'b0;
			ackTgl <= 1'b0;
			linkRdata <= BYTE_RESET;
			fetchAddr <= ADDR_RESET;
			instrSeen <= 1'b0;
			instrDone <= 1'b0;
		end else begin
			case (state)
				L_IDLE: begin
					if (!lWaitN && (instrDone || lInstrTgl != instrSeen)) begin
						state <= L_WAIT;
					end else if (lReqTgl != reqSeen) begin
						reqSeen <= lReqTgl;
						cur <= reqHold; // Held stable by the mclk side until acked
						state <= L_T1;
					end
				end
				L_T1: begin
					if (cur.req.kind == ACC_FETCH) begin
						fetchAddr <= cur.req.memAddr;
						instrDone <= 1'b0;
					end
					cnt <= cur.extended ? 4'(STROBE_CYCLES + EXTEND_CYCLES) : STROBE_CYCLES;
					state <= L_T2;
				end
				L_T2: begin
					if (cnt == 4'h1) begin
						state <= L_T3;
					end
					cnt <= cnt - 4'h1;
				end
				L_T3: begin
					// Taken one state late: the pin filter settles only after the last strobe cycle
					linkRdata <= isMem ? lMemRd : lRegRd;
					ackTgl <= ~ackTgl;
					state <= L_IDLE;
				end
				L_WAIT: begin
					if (lWaitN) begin
						instrDone <= 1'b0;
						state <= L_IDLE;
					end
				end
				default: state <= L_IDLE;
			endcase
			// After the clears, so a boundary in the same cycle is not lost
			if (lInstrTgl != instrSeen) begin
				instrSeen <= lInstrTgl;
				instrDone <= 1'b1; // Instruction boundary reached
			end
		end
	end

	// Register bus pins
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			regBankPtr <= ONBOARD_BANK;
			regAddrBus <= BYTE_RESET;
			regWriteBus <= BYTE_RESET;
			regWriteStrobeN <= 1'b1;
			regReadStrobeN <= 1'b1;
			extRegfileSelectN <= 1'b1;
		end else begin
			regWriteStrobeN <= 1'b1;
			regReadStrobeN <= 1'b1;
			extRegfileSelectN <= 1'b1;
			if (!isMem && (state == L_T1 || state == L_T2)) begin
				regBankPtr <= cur.req.bank;
				regAddrBus <= cur.req.regAddr;
				extRegfileSelectN <= cur.req.bank == ONBOARD_BANK;
				if (cur.req.kind == ACC_REG_WRITE) begin
					regWriteBus <= cur.req.wdata;
				end
				if (state == L_T2) begin
					regWriteStrobeN <= cur.req.kind != ACC_REG_WRITE;
					regReadStrobeN <= cur.req.kind != ACC_REG_READ;
				end
			end
		end
	end

	// Memory bus pins and strobes
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			memAddrBus <= ADDR_RESET;
			memDataBusOut <= BYTE_RESET;
			memDataBusOe <= 1'b0;
			dataSpaceStrobeN <= 1'b1;
			intMemDataStrobeN <= 1'b1;
			intMemAddrStrobeN <= 1'b1;
			extDataStrobeN <= 1'b1;
			extAddrStrobeN <= 1'b1;
		end else begin
			memDataBusOe <= 1'b0;
			dataSpaceStrobeN <= 1'b1;
			intMemDataStrobeN <= 1'b1;
			intMemAddrStrobeN <= 1'b1;
			extDataStrobeN <= 1'b1;
			extAddrStrobeN <= 1'b1;
			if (state == L_WAIT) begin
				memAddrBus <= fetchAddr;
				extDataStrobeN <= 1'b0;
			end else if (isMem && state == L_T1) begin
				memAddrBus <= cur.req.memAddr;
				intMemAddrStrobeN <= 1'b0;
				extAddrStrobeN <= 1'b0;
				dataSpaceStrobeN <= cur.req.kind == ACC_FETCH;
			end else if (isMem && state == L_T2) begin
				dataSpaceStrobeN <= cur.req.kind == ACC_FETCH;
				intMemDataStrobeN <= !isIntFetch;
				extDataStrobeN <= isIntFetch;
				if (cur.req.kind == ACC_DATA_WRITE) begin
					memDataBusOut <= cur.req.wdata;
					memDataBusOe <= 1'b1;
				end
				// Shared lines carry data after the address state
				if (!lMuxN) begin
					memAddrBus[7:0] <= cur.req.kind == ACC_DATA_WRITE ? cur.req.wdata : lMemRd;
				end
			end
		end
	end

	// Status pins from the core
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			instrSync <= 1'b0;
			intAckN <= 1'b1;
			haltIndN <= 1'b1;
			stopIndN <= 1'b1;
		end else begin
			instrSync <= lInstrTgl != instrSeen;
			intAckN <= ~lIntCycle;
			haltIndN <= ~lHalt;
			stopIndN <= ~lStop;
		end
	end

	// System and timer clocks: the link clock keeps running, hold freezes the divider
	always_ff @(posedge linkClk) begin
		if (lRst) begin
			sysClk <= 1'b0;
			sysClkInv <= 1'b1;
			timerTickClk <= 1'b0;
		end else if (lHoldN) begin
			sysClk <= ~sysClk;
			sysClkInv <= sysClk;
			timerTickClk <= ~timerTickClk;
		end
	end

endmodule : emu_core_bus_interface

//--- emu_core_bus_interface_properties.sv
/*
 * Pin-level properties of the emulation bus interface, on the link clock.
 * Assumes binding to emu_core_bus_interface and rst active high.
 */
module emu_core_bus_interface_properties
	import emu_bus_pkg::*;
(
	input wire logic linkClk,
	input wire logic rst,
	input wire logic [3:0] regBankPtr,
	input wire logic [7:0] regAddrBus,
	input wire logic [7:0] regWriteBus,
	input wire logic regWriteStrobeN,
	input wire logic regReadStrobeN,
	input wire logic extRegfileSelectN,
	input wire logic dataSpaceStrobeN,
	input wire logic intMemDataStrobeN,
	input wire logic intMemAddrStrobeN,
	input wire logic extDataStrobeN,
	input wire logic extAddrStrobeN,
	input wire logic instrSync,
	input wire logic clockHoldN,
	input wire logic sysClk,
	input wire logic sysClkInv
);
	// All pin checks live on the link clock
	default clocking cb @(posedge linkClk);
	endclocking
	default disable iff (rst);

	property p_wr;
		!regWriteStrobeN && $past(!regWriteStrobeN) |-> $stable({regWriteBus, regAddrBus}) && regReadStrobeN;
	endproperty
	a_wr: assert property (p_wr) else $error("write cycle unsteady");
	property p_rd;
		!regReadStrobeN |-> regWriteStrobeN;
	endproperty
	a_rd: assert property (p_rd) else $error("read and write strobes together");
	property p_addr;
		!regReadStrobeN && $past(!regReadStrobeN) |-> $stable({regBankPtr, regAddrBus});
	endproperty
	a_addr: assert property (p_addr) else $error("register address moved");
	property p_sel;
		!(regReadStrobeN && regWriteStrobeN) |-> extRegfileSelectN == (regBankPtr == ONBOARD_BANK);
	endproperty
	a_sel: assert property (p_sel) else $error("select wrong for bank");
	property p_dm;
		!dataSpaceStrobeN |-> intMemDataStrobeN;
	endproperty
	a_dm: assert property (p_dm) else $error("data access used internal strobe");
	property p_mds;
		!intMemDataStrobeN |-> extDataStrobeN;
	endproperty
	a_mds: assert property (p_mds) else $error("both data strobes low");
	property p_as;
		$fell(intMemAddrStrobeN) |-> !extAddrStrobeN;
	endproperty
	a_as: assert property (p_as) else $error("address strobes apart");
	property p_sync;
		instrSync |=> !instrSync;
	endproperty
	a_sync: assert property (p_sync) else $error("sync longer than one clock");
	property p_inv;
		sysClkInv != sysClk;
	endproperty
	a_inv: assert property (p_inv) else $error("inverted clock not inverse");
	// Filter delay of the hold pin is covered by the eight-cycle run-in
	property p_hold;
		!clockHoldN [*8] |-> $stable(sysClk);
	endproperty
	a_hold: assert property (p_hold) else $error("clock ran during hold");

	c_wr: cover property (!regWriteStrobeN);
	c_wait: cover property (!extDataStrobeN && extAddrStrobeN);
	c_mem: cover property ($fell(intMemAddrStrobeN));
endmodule : emu_core_bus_interface_properties

//--- emu_regfile_model.sv
/*
 * Far side: expanded register file and emulator memory.
 * Assumes strobes active low and one linkClk of answer latency.
 */
module emu_regfile_model (
	input wire logic linkClk,
	input wire logic [3:0] regBankPtr,
	input wire logic [7:0] regAddrBus,
	input wire logic [7:0] regWriteBus,
	input wire logic regWriteStrobeN,
	input wire logic regReadStrobeN,
	output logic [7:0] regReadBus = 8'h00,
	input wire logic [15:0] memAddrBus,
	input wire logic extAddrStrobeN,
	input wire logic intMemAddrStrobeN,
	input wire logic extDataStrobeN,
	input wire logic intMemDataStrobeN,
	output logic [7:0] memDataBusIn = 8'h00
);
	logic [7:0] regs [0:4095];
	logic [15:0] addr = 16'h0000;

	// Released buses toggle so a stale sample never matches
	always @(posedge linkClk) begin
		if (!regWriteStrobeN) regs[{regBankPtr, regAddrBus}] <= regWriteBus;
		regReadBus <= !regReadStrobeN ? regs[{regBankPtr, regAddrBus}] : ~regReadBus;
		if (!(extAddrStrobeN && intMemAddrStrobeN)) addr <= memAddrBus;
		memDataBusIn <= !(extDataStrobeN && intMemDataStrobeN) ? addr[7:0] ^ addr[15:8] ^ 8'h3C : ~memDataBusIn;
	end
endmodule : emu_regfile_model

//--- emu_core_bus_interface_tb.sv
/*
 * Testbench of the emulation bus interface with the far-side model.
 * Assumes mclk at 8 ns and an unrelated 6 ns link clock.
 */
module emu_core_bus_interface_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import emu_bus_pkg::*;
	logic mclk = 0, linkClk = 0, rst = 1, reqValid = 0, emuCtrlWrite = 0, addrDataMuxSelN = 1;
	logic timersFreezeN = 1, clockHoldN = 1, waitN = 1, stopWakeN = 1, mds, ds, dm, oe, sel;
	logic reqBusy, rspValid, memDataBusOe, regWriteStrobeN, regReadStrobeN, extRegfileSelectN, dataSpaceStrobeN;
	logic intMemDataStrobeN, intMemAddrStrobeN, extDataStrobeN, extAddrStrobeN, instrSync, intAckN;
	logic haltIndN, stopIndN, sysClk, sysClkInv, timerTickClk;
	logic [2:0] memSizeSel = SIZE_32K;
	logic [3:0] regBankPtr;
	logic [7:0] emuCtrlData = 8'h00, rspData, emuControlReg, memDataBusIn, memDataBusOut, regAddrBus;
	logic [7:0] regWriteBus, regReadBus, outVal, lowAddr;
	logic [15:0] memAddrBus;
	core_req_t req = '0;
	core_status_t coreStatus = '0;
	core_ctrl_t coreCtrl;
	int err_total = 0, checks_done = 0, rdLow;

	// Link clock offset so its edges wander against mclk
	always #4 mclk = ~mclk;
	initial begin
		#1.3;
		forever #3 linkClk = ~linkClk;
	end

	emu_core_bus_interface i_dut (.mclk, .rst, .linkClk, .reqValid, .req, .reqBusy, .rspValid, .rspData,
		.emuCtrlWrite, .emuCtrlData, .emuControlReg, .coreStatus, .coreCtrl, .addrDataMuxSelN, .memSizeSel,
		.memAddrBus, .memDataBusIn, .memDataBusOut, .memDataBusOe, .regBankPtr, .regAddrBus, .regWriteBus,
		.regReadBus, .regWriteStrobeN, .regReadStrobeN, .extRegfileSelectN, .dataSpaceStrobeN,
		.intMemDataStrobeN, .intMemAddrStrobeN, .extDataStrobeN, .extAddrStrobeN, .instrSync, .intAckN,
		.timersFreezeN, .clockHoldN, .waitN, .haltIndN, .stopIndN, .stopWakeN, .sysClk, .sysClkInv,
		.timerTickClk);
	emu_regfile_model i_far (.linkClk, .regBankPtr, .regAddrBus, .regWriteBus, .regWriteStrobeN,
		.regReadStrobeN, .regReadBus, .memAddrBus, .extAddrStrobeN, .intMemAddrStrobeN, .extDataStrobeN,
		.intMemDataStrobeN, .memDataBusIn);

	// Pin activity of the current access
	always @(posedge linkClk) begin
		if (!regReadStrobeN) rdLow++;
		mds |= !intMemDataStrobeN;
		ds |= !extDataStrobeN;
		dm |= !dataSpaceStrobeN;
		sel |= !extRegfileSelectN;
		if (memDataBusOe) begin
			oe = 1;
			outVal = memDataBusOut;
			lowAddr = memAddrBus[7:0];
		end
	end

	function automatic logic [7:0] memVal(input logic [15:0] m);
		return m[7:0] ^ m[15:8] ^ 8'h3C;
	endfunction : memVal

	task automatic complete_run;
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic hang(input logic stuck);
		if (stuck) begin
			err_total++;
			complete_run();
		end
	endtask : hang

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask : idle

	// One core request, valid for one mclk cycle, answer awaited for up to 200 cycles
	task automatic access(input access_kind_t k, input logic [3:0] b, input logic [7:0] a, input logic [15:0] m,
		input logic [7:0] w);
		int i;
		@(negedge mclk);
		req = '{k, b, a, w, m};
		{mds, ds, dm, oe, sel} = 5'h00;
		rdLow = 0;
		reqValid = 1;
		@(negedge mclk);
		reqValid = 0;
		for (i = 0; i < 200 && rspValid !== 1'b1; i++) @(negedge mclk);
		hang(i == 200);
	endtask : access

	task automatic t_regs;
		for (int x = 0; x < 2; x++) begin
			emuCtrlWrite = 1;
			emuCtrlData = 8'(x);
			idle(1);
			emuCtrlWrite = 0;
			chk(emuControlReg, 8'(x));
			access(ACC_REG_WRITE, 4'(1 + x * 14), 8'(8'hA5 + x), 16'h0, 8'(8'h5A ^ x));
			chk(sel, 1'b1);
			access(ACC_REG_READ, 4'(1 + x * 14), 8'(8'hA5 + x), 16'h0, 8'h00);
			chk(rspData, 8'(8'h5A ^ x));
			chk(16'(rdLow), 16'(STROBE_CYCLES + (x ? EXTEND_CYCLES : 4'h0)));
		end
		access(ACC_REG_WRITE, ONBOARD_BANK, 8'h10, 16'h0, 8'h77);
		chk(sel, 1'b0);
	endtask : t_regs

	// Boundary fetch on both sides of each memory size, only at address 0 for SIZE_NONE
	task automatic t_fetch;
		int sz;
		for (int c = 0; c < 8; c++) begin
			memSizeSel = 3'(c);
			sz = (c == 0) ? 0 : 1024 << (c > 5 ? 5 : c);
			idle(8);
			access(ACC_FETCH, 4'h0, 8'h00, 16'(sz), 8'h00);
			chk({ds, mds, rspData}, {2'b10, memVal(16'(sz))});
			if (c > 0) begin
				access(ACC_FETCH, 4'h0, 8'h00, 16'(sz - 1), 8'h00);
				chk({ds, mds, rspData}, {2'b01, memVal(16'(sz - 1))});
			end
		end
	endtask : t_fetch

	task automatic t_data;
		for (int mx = 0; mx < 2; mx++) begin
			addrDataMuxSelN = 1'(mx);
			idle(8);
			access(ACC_DATA_WRITE, 4'h0, 8'h00, 16'h12B4, 8'hC3);
			chk({dm, oe, outVal, lowAddr}, {2'b11, 8'hC3, mx ? 8'hB4 : 8'hC3});
			access(ACC_DATA_READ, 4'h0, 8'h00, 16'h12B4, 8'h00);
			chk({dm, ds, mds, rspData}, {3'b110, memVal(16'h12B4)});
		end
	endtask : t_data

	task automatic t_status;
		int i;
		coreStatus.instrEnd = 1;
		idle(1);
		coreStatus.instrEnd = 0;
		for (i = 0; i < 40 && instrSync !== 1'b1; i++) @(negedge linkClk);
		hang(i == 40);
		coreStatus = core_status_t'(4'h7);
		idle(20);
		chk({intAckN, haltIndN, stopIndN}, 3'b000);
		coreStatus = '0;
		idle(20);
		chk({intAckN, haltIndN, stopIndN}, 3'b111);
	endtask : t_status

	// Control pins low, then high; hold also freezes the clock outputs
	task automatic t_pins;
		logic [1:0] clkNow;
		{timersFreezeN, clockHoldN, waitN, stopWakeN} = 4'h0;
		idle(20);
		chk(coreCtrl, 4'h7);
		clkNow = {sysClk, timerTickClk};
		idle(4);
		chk({sysClk, timerTickClk, sysClkInv}, {clkNow, ~clkNow[1]});
		{timersFreezeN, clockHoldN, waitN, stopWakeN} = 4'hF;
		idle(20);
		chk(coreCtrl, 4'h8);
		chk(timerTickClk, sysClk);
	endtask : t_pins

	task automatic t_wait;
		access(ACC_FETCH, 4'h0, 8'h00, 16'h4321, 8'h00);
		waitN = 0;
		idle(4);
		coreStatus.instrEnd = 1;
		idle(1);
		coreStatus.instrEnd = 0;
		idle(20);
		chk({extAddrStrobeN, extDataStrobeN, memAddrBus}, {2'b10, 16'h4321});
		waitN = 1;
		idle(20);
		chk({extAddrStrobeN, extDataStrobeN}, 2'b11);
	endtask : t_wait

	// Reset longer than three cycles so the link side also clears
	initial begin
		idle(6);
		rst = 0;
		idle(12);
		chk({haltIndN, stopIndN, intAckN, extRegfileSelectN}, 4'hF);
		chk(emuControlReg, EMU_CTRL_RESET);
		t_regs();
		t_fetch();
		t_data();
		t_status();
		t_pins();
		t_wait();
		complete_run();
	end
endmodule : emu_core_bus_interface_tb

bind emu_core_bus_interface emu_core_bus_interface_properties i_chk (.linkClk, .rst, .regBankPtr, .regAddrBus,
	.regWriteBus, .regWriteStrobeN, .regReadStrobeN, .extRegfileSelectN, .dataSpaceStrobeN, .intMemDataStrobeN,
	.intMemAddrStrobeN, .extDataStrobeN, .extAddrStrobeN, .instrSync, .clockHoldN, .sysClk, .sysClkInv);
